// File: rtl/lfc_top.sv
// line front-end control: termination, driver high impedance, power
// down, monitor gain, equalizer, observation window, slicer routing.
// assumes a byte register port and pins asynchronous to CLK.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
// Summary of operation
// - tx termination: internal code or external
// - t1/j1 forces internal tx termination
// - hardware impedance pin and template pins
// - driver high-z bit tri-states tx pair
// - hardware high-z pin tri-states tx pair
// - other high-z causes: reset, clock loss
// - tx power-down bit powers down, tri-states
// - hardware power-down needs both pattern pins
// - rx termination: internal code or external
// - monitor gain 0, 22, 26, 32 dB
// - hardware monitor pin: 0 or 26 dB
// - loss of signal invalid in monitor mode
// - equalizer enable bit
// - equalizer out-of-range status flag
// - status edge sets interrupt flag
// - interrupt flag clears on read
// - observation window 32..256, default 128
// - cable attenuation readout, 2 dB steps
// - slicer threshold 40..70 percent
// - slicer to recovery or straight to rails
// - hardware haul pin picks short/long haul
module lfc_top #(
  parameter logic [7:0] HOLD = lfc_pkg::HOLD_CYC // hi-z cycles after reset
) (
  input  wire logic       CLK,                 // 25 MHz master clock
  input  wire logic       RST_N,               // async reset, low
  input  wire logic [7:0] ADDR,                // register address
  input  wire logic [7:0] WR_DATA,             // write data
  input  wire logic       WR_EN,               // write strobe
  input  wire logic       RD_EN,               // read strobe
  output logic      [7:0] RD_DATA,             // read data, next cycle
  input  wire logic       HW_MODE,             // pin: hardware control
  input  wire logic       TERM_PIN,            // pin: 1 internal match
  input  wire logic [3:0] PULSE_TEMPLATE_PINS, // pin: template select
  input  wire logic       DRIVER_HIZ_PIN,      // pin: tx high-z
  input  wire logic       PATTERN_PIN_HI,      // pin: pattern select 1
  input  wire logic       PATTERN_PIN_LO,      // pin: pattern select 0
  input  wire logic       MONITOR_GAIN_PIN,    // pin: 26 dB monitor
  input  wire logic       HAUL_SELECT_PIN,     // pin: 1 long haul
  input  wire logic       EQ_RANGE_IN,         // analog: out of range
  input  wire logic [4:0] CABLE_ATTEN_IN,      // analog: attenuation
  input  wire logic       SLICE_P_IN,          // analog: slicer mark +
  input  wire logic       SLICE_N_IN,          // analog: slicer mark -
  input  wire logic       CDR_BYPASS,          // recovery disabled
  input  wire logic       CDR_P,               // recovered positive
  input  wire logic       CDR_N,               // recovered negative
  input  wire logic       TX_CLOCK_LOST,       // tx clock missing
  input  wire logic       REMOTE_LOOPBACK,     // remote loopback on
  input  wire logic       PATTERN_BY_MCLK,     // pattern on master clock
  output logic            TX_LINE_PAIR_OE_N,   // 1: tx pair high-z
  output logic            TX_POWER_DOWN,       // tx path off
  output logic            TX_TERM_INTERNAL,    // tx internal match
  output logic      [1:0] TX_TERM_CODE,        // tx impedance code
  output logic            RX_TERM_INTERNAL,    // rx internal match
  output logic      [1:0] RX_TERM_CODE,        // rx impedance code
  output logic      [5:0] MONITOR_GAIN_DB,     // monitor boost in dB
  output logic            SIGNAL_LOSS_VALID,   // loss report usable
  output logic            EQUALIZER_ENABLE,    // equalizer running
  output logic      [8:0] OBSERVE_WINDOW,      // symbols per window
  output logic      [6:0] THRESHOLD_PCT,       // slicer threshold %
  output logic            LONG_HAUL,           // long haul receive
  output logic            RX_RAIL_P,           // rx positive rail
  output logic            RX_RAIL_N,           // rx negative rail
  output logic            IRQ                  // interrupt, high
);
  import lfc_pkg::*;
  localparam int NS = 19;

  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  logic [7:0] imp_select;
  logic [7:0] tx_power_ctrl;
  logic [7:0] tx_driver_ctrl;
  logic [7:0] rx_equalizer_ctrl;
  logic [7:0] rx_gain_threshold_ctrl;
  logic [7:0] int_edge_select;
  logic [7:0] line_mode_ctrl;
  logic [7:0] int_mask_ctrl;
  logic [7:0] hold_cnt;
  logic [7:0] next_rd;
  logic       hw, s_term, s_thz, s_phi, s_plo, s_monitor_gain_pin, s_haul;
  logic       s_range, s_slp, s_sln;
  logic [3:0] s_puls;
  logic [4:0] s_att;
  logic       t1_mode, sw_reset, tx_pd, drv_hiz, clk_loss_hiz;
  logic       next_hiz, next_tx_int, next_rx_int;
  logic [1:0] next_tx_code, next_rx_code;
  logic [1:0] gain_sel;
  lfc_term_type hw_code;
  lfc_eq_if   eq ();

  // every pin passes two flops before use
  assign pin_raw = {HW_MODE, TERM_PIN, PULSE_TEMPLATE_PINS,
                    DRIVER_HIZ_PIN, PATTERN_PIN_HI, PATTERN_PIN_LO,
                    MONITOR_GAIN_PIN, HAUL_SELECT_PIN, EQ_RANGE_IN,
                    CABLE_ATTEN_IN, SLICE_P_IN, SLICE_N_IN};
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sync
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
        end else begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate
  assign {hw, s_term, s_puls, s_thz, s_phi, s_plo, s_monitor_gain_pin, s_haul,
          s_range, s_att, s_slp, s_sln} = sync2;

  // template pins map onto one impedance; long haul sets use 100 ohm
  function automatic lfc_term_type puls_to_term(input logic [3:0] p);
    case (p)
      4'h0:    puls_to_term = TERM_75;
      4'h1:    puls_to_term = TERM_120;
      4'h7:    puls_to_term = TERM_110;
      default: puls_to_term = TERM_100;
    endcase
  endfunction

  // monitor gain code to dB
  function automatic logic [5:0] gain_db(input logic [1:0] c);
    case (c)
      GAIN_22: gain_db = 6'h16;
      GAIN_26: gain_db = 6'h1A;
      GAIN_32: gain_db = 6'h20;
      default: gain_db = 6'h00;
    endcase
  endfunction

  assign sw_reset = WR_EN && ADDR == ADDR_MODE && WR_DATA[SWRST_BIT];
  assign t1_mode  = line_mode_ctrl[T1_BIT];
  assign hw_code  = puls_to_term(s_puls);

  // control registers; software reset restores defaults
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      imp_select             <= IMP_RST;
      tx_power_ctrl          <= CTRL_RST;
      tx_driver_ctrl         <= CTRL_RST;
      rx_equalizer_ctrl      <= CTRL_RST;
      rx_gain_threshold_ctrl <= GAIN_RST;
      int_edge_select        <= CTRL_RST;
      line_mode_ctrl         <= CTRL_RST;
      int_mask_ctrl          <= CTRL_RST;
    end else if (sw_reset) begin
      imp_select             <= IMP_RST;
      tx_power_ctrl          <= CTRL_RST;
      tx_driver_ctrl         <= CTRL_RST;
      rx_equalizer_ctrl      <= CTRL_RST;
      rx_gain_threshold_ctrl <= GAIN_RST;
      int_edge_select        <= CTRL_RST;
      line_mode_ctrl         <= CTRL_RST;
      int_mask_ctrl          <= CTRL_RST;
    end else if (WR_EN) begin
      case (ADDR)
        ADDR_IMP:   imp_select             <= WR_DATA;
        ADDR_TXPWR: tx_power_ctrl          <= WR_DATA;
        ADDR_TXDRV: tx_driver_ctrl         <= WR_DATA;
        ADDR_EQ:    rx_equalizer_ctrl      <= WR_DATA;
        ADDR_GAIN:  rx_gain_threshold_ctrl <= WR_DATA;
        ADDR_EDGE:  int_edge_select        <= WR_DATA;
        ADDR_MODE:  line_mode_ctrl         <= WR_DATA;
        ADDR_MASK:  int_mask_ctrl          <= WR_DATA;
        default:    ;
      endcase
    end
  end

  // drivers stay high-z for a while after any reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_cnt <= 8'h00;
    end else if (sw_reset) begin
      hold_cnt <= 8'h00;
    end else if (hold_cnt != HOLD) begin
      hold_cnt <= hold_cnt + 8'h01;
    end
  end

  // power down and high-z sources, pins win in hardware mode
  assign tx_pd   = hw ? (s_phi & s_plo)
                      : tx_power_ctrl[0];
  assign drv_hiz = hw ? s_thz
                      : tx_driver_ctrl[0];
  assign clk_loss_hiz = TX_CLOCK_LOST & ~REMOTE_LOOPBACK &
                        ~PATTERN_BY_MCLK;
  assign next_hiz = drv_hiz | tx_pd | clk_loss_hiz | sw_reset |
                    (hold_cnt != HOLD);

  // termination choice for both directions
  always_comb begin
    if (hw) begin
      next_rx_int  = s_term;
      next_rx_code = hw_code;
      next_tx_int  = s_term | t1_mode;
      next_tx_code = hw_code;
    end else begin
      next_rx_int  = ~imp_select[RX_TERM_LSB+TERM_EXT];
      next_rx_code = imp_select[RX_TERM_LSB +: 2];
      next_tx_int  = ~imp_select[TX_TERM_LSB+TERM_EXT] |
                     t1_mode;
      next_tx_code = imp_select[TX_TERM_LSB +: 2];
    end
  end

  assign gain_sel = hw ? (s_monitor_gain_pin ? GAIN_26 : GAIN_0)
                       : rx_gain_threshold_ctrl[MG_LSB +: 2];

  // registered control outputs; tx circuits keep running under high-z
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TX_LINE_PAIR_OE_N <= 1'b1;
      TX_POWER_DOWN     <= 1'b0;
      TX_TERM_INTERNAL  <= 1'b1;
      TX_TERM_CODE      <= 2'b00;
      RX_TERM_INTERNAL  <= 1'b1;
      RX_TERM_CODE      <= 2'b00;
    end else begin
      TX_LINE_PAIR_OE_N <= next_hiz;
      TX_POWER_DOWN     <= tx_pd;
      TX_TERM_INTERNAL  <= next_tx_int;
      TX_TERM_CODE      <= next_tx_code;
      RX_TERM_INTERNAL  <= next_rx_int;
      RX_TERM_CODE      <= next_rx_code;
    end
  end

  // receive path settings
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MONITOR_GAIN_DB   <= 6'h00;
      SIGNAL_LOSS_VALID <= 1'b1;
      EQUALIZER_ENABLE  <= 1'b0;
      OBSERVE_WINDOW    <= WIN_BASE;
      THRESHOLD_PCT     <= PCT_BASE;
      LONG_HAUL         <= 1'b0;
    end else begin
      MONITOR_GAIN_DB   <= gain_db(gain_sel);
      SIGNAL_LOSS_VALID <= gain_sel == GAIN_0;
      EQUALIZER_ENABLE  <= rx_equalizer_ctrl[0];
      OBSERVE_WINDOW    <= WIN_BASE <<
        rx_gain_threshold_ctrl[WIN_LSB +: 2];
      THRESHOLD_PCT     <= PCT_BASE + PCT_STEP *
        {5'h00, rx_gain_threshold_ctrl[SLICE_LSB +: 2]};
      LONG_HAUL         <= hw ? s_haul
                              : line_mode_ctrl[LH_BIT];
    end
  end

  // slicer straight to rails when recovery is bypassed
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RX_RAIL_P <= 1'b0;
      RX_RAIL_N <= 1'b0;
    end else begin
      RX_RAIL_P <= CDR_BYPASS ? s_slp : CDR_P;
      RX_RAIL_N <= CDR_BYPASS ? s_sln : CDR_N;
    end
  end

  // equalizer event logic lives in its own module
  assign eq.range_flag = s_range;
  assign eq.edge_sel   = int_edge_select[0];
  assign eq.int_mask   = int_mask_ctrl[0];
  assign eq.rd_clear   = RD_EN && ADDR == ADDR_INTA;
  assign IRQ           = eq.irq;

  lfc_eq_event u_evt (
    .clk   (CLK),
    .rst_n (RST_N),
    .eq    (eq.evt)
  );

  // read mux; unmapped offsets read zero
  always_comb begin
    case (ADDR)
      ADDR_IMP:   next_rd = imp_select;
      ADDR_TXPWR: next_rd = tx_power_ctrl;
      ADDR_TXDRV: next_rd = tx_driver_ctrl;
      ADDR_EQ:    next_rd = rx_equalizer_ctrl;
      ADDR_GAIN:  next_rd = rx_gain_threshold_ctrl;
      ADDR_EDGE:  next_rd = int_edge_select;
      ADDR_LSTAT: next_rd = {7'h00, s_range};
      ADDR_CABLE: next_rd = {3'h0, s_att};
      ADDR_INTA:  next_rd = {7'h00, eq.int_flag};
      ADDR_MODE:  next_rd = {1'b0, line_mode_ctrl[6:0]};
      ADDR_MASK:  next_rd = int_mask_ctrl;
      default:    next_rd = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_DATA <= 8'h00;
    end else if (RD_EN) begin
      RD_DATA <= next_rd;
    end else begin
      RD_DATA <= 8'h00;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_drv_hiz_bit: assert property (
    (!hw && tx_driver_ctrl[0]) |=> TX_LINE_PAIR_OE_N)
    else $error("driver high-z bit ignored");
  chk_hiz_pin: assert property (
    (hw && s_thz) |=> TX_LINE_PAIR_OE_N)
    else $error("high-z pin ignored");
  chk_pd_hiz: assert property (
    tx_pd |=> (TX_POWER_DOWN && TX_LINE_PAIR_OE_N))
    else $error("power down without high-z");
  chk_hw_pd_pins: assert property (
    (hw && !(s_phi && s_plo)) |=> !TX_POWER_DOWN)
    else $error("hardware power down with one pattern pin");
  chk_t1_internal: assert property (
    t1_mode |=> TX_TERM_INTERNAL)
    else $error("external tx match in t1 mode");
  chk_sw_term_code: assert property (
    (!hw && !t1_mode) |=> (TX_TERM_INTERNAL ==
      !$past(imp_select[TX_TERM_LSB+TERM_EXT])))
    else $error("tx termination select not applied");
  chk_hw_term_pin: assert property (
    hw |=> (RX_TERM_INTERNAL == $past(s_term)))
    else $error("hardware term pin not applied");
  chk_monitor_gain_pin_gain: assert property (
    (hw && s_monitor_gain_pin) |=> (MONITOR_GAIN_DB == 6'h1A && !SIGNAL_LOSS_VALID))
    else $error("monitor pin gain wrong");
  chk_clk_loss_hiz: assert property (
    clk_loss_hiz |=> TX_LINE_PAIR_OE_N)
    else $error("tx clock loss without high-z");
  chk_rail_bypass: assert property (
    CDR_BYPASS |=> (RX_RAIL_P == $past(s_slp)))
    else $error("slicer not routed to rails");
  chk_irq_follow: assert property (
    (eq.rd_clear && s_range == $past(s_range)) |=> !IRQ)
    else $error("interrupt stayed up after status read");
endmodule

// File: rtl/lfc_pkg.sv
// line front-end control: register map, field layout, reset values.
// assumes a byte-wide register port on the single 25 MHz master clock.
package lfc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_IMP   = 8'h03;
  localparam logic [7:0] ADDR_TXPWR = 8'h05;
  localparam logic [7:0] ADDR_TXDRV = 8'h06;
  localparam logic [7:0] ADDR_EQ    = 8'h0B;
  localparam logic [7:0] ADDR_GAIN  = 8'h0C;
  localparam logic [7:0] ADDR_EDGE  = 8'h16;
  localparam logic [7:0] ADDR_LSTAT = 8'h17;
  localparam logic [7:0] ADDR_CABLE = 8'h18;
  localparam logic [7:0] ADDR_INTA  = 8'h19;
  localparam logic [7:0] ADDR_MODE  = 8'h1C;
  localparam logic [7:0] ADDR_MASK  = 8'h1D;
  // field positions
  localparam int TX_TERM_LSB = 0;
  localparam int RX_TERM_LSB = 3;
  localparam int TERM_EXT    = 2;
  localparam int SLICE_LSB   = 0;
  localparam int WIN_LSB     = 2;
  localparam int MG_LSB      = 4;
  localparam int T1_BIT      = 0;
  localparam int LH_BIT      = 1;
  localparam int SWRST_BIT   = 7;
  // reset values
  localparam logic [7:0] IMP_RST   = 8'h00;
  localparam logic [7:0] GAIN_RST  = 8'h08;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  // timing and scaling
  localparam logic [7:0] HOLD_CYC  = 8'h10;
  localparam logic [8:0] WIN_BASE  = 9'h020;
  localparam logic [6:0] PCT_BASE  = 7'h28;
  localparam logic [6:0] PCT_STEP  = 7'h0A;
  // gain codes and impedance codes
  typedef enum logic [1:0] {
    GAIN_0 = 2'b00, GAIN_22 = 2'b01, GAIN_26 = 2'b10, GAIN_32 = 2'b11
  } lfc_gain_type;
  typedef enum logic [1:0] {
    TERM_75 = 2'b00, TERM_120 = 2'b01, TERM_100 = 2'b10, TERM_110 = 2'b11
  } lfc_term_type;
endpackage

// File: rtl/lfc_eq_if.sv
// carrier between the register side and the equalizer event logic.
// assumes both ends share the master clock.
`timescale 1ns/1ps
interface lfc_eq_if;
  logic range_flag;  // synchronised out-of-range status
  logic edge_sel;    // 1: both edges raise the event
  logic int_mask;    // 1: event may reach the interrupt
  logic rd_clear;    // read of the interrupt status register
  logic int_flag;    // sticky event flag
  logic irq;         // gated interrupt
  modport ctl (output range_flag, edge_sel, int_mask, rd_clear,
               input int_flag, irq);
  modport evt (input range_flag, edge_sel, int_mask, rd_clear,
               output int_flag, irq);
endinterface

// File: rtl/lfc_eq_event.sv
// equalizer status edge detector with a read-to-clear flag.
// assumes range_flag is already synchronised to CLK.
`timescale 1ns/1ps
module lfc_eq_event (
  input  wire logic clk,   // master clock
  input  wire logic rst_n, // async reset, low
  lfc_eq_if.evt     eq     // status and flag carrier
);
  import lfc_pkg::*;
  logic prev;
  logic event_hit;

  // rise always counts, fall only with both-edge select
  assign event_hit = (eq.range_flag & ~prev) |
                     (eq.edge_sel & ~eq.range_flag & prev);

  // previous status for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= eq.range_flag;
    end
  end

  // set wins over the read clear so no edge is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eq.int_flag <= 1'b0;
    end else if (event_hit) begin
      eq.int_flag <= 1'b1;
    end else if (eq.rd_clear) begin
      eq.int_flag <= 1'b0;
    end
  end

  assign eq.irq = eq.int_flag & eq.int_mask;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_rise;
    !eq.range_flag ##1 eq.range_flag;
  endsequence
  sequence s_fall;
    eq.range_flag ##1 !eq.range_flag;
  endsequence

  chk_rise_sets_flag: assert property (
    s_rise |=> eq.int_flag)
    else $error("rising status did not set flag");
  chk_fall_edge_sel: assert property (
    (s_fall ##0 eq.edge_sel) |=> eq.int_flag)
    else $error("falling status with both edges did not set flag");
  chk_clear_on_read: assert property (
    (eq.rd_clear && !event_hit) |=> !eq.int_flag)
    else $error("flag not cleared by read");
endmodule

// File: verification/lfc_line_model.sv
// far-side line model: equalizer status, cable loss and slicer marks.
// assumes the bench sets the wanted line condition between clock edges.
`timescale 1ns/1ps
module lfc_line_model (
  input  wire logic       clk,              // master clock
  input  wire logic       out_of_range,     // wanted equalizer status
  input  wire logic [4:0] atten,            // wanted cable loss steps
  input  wire logic [1:0] mark,             // 10 plus mark, 01 minus mark
  output logic            range_out = 1'b0, // to status input
  output logic      [4:0] atten_out = 5'h00, // to attenuation input
  output logic            slice_p = 1'b0,   // slicer positive mark
  output logic            slice_n = 1'b0    // slicer negative mark
);
  // conditions move only after an edge, like the analog front end
  always @(posedge clk) begin
    range_out <= out_of_range;
    atten_out <= atten;
    // a bipolar line never carries both marks at once
    slice_p   <= mark[1];
    slice_n   <= mark[0] & ~mark[1];
  end
endmodule

// File: verification/lfc_top_tb_top.sv
// self-checking bench for the line front-end control block.
// assumes lfc_pkg and the line model; hold shortened to 2 cycles.
`timescale 1ns/1ps
module lfc_top_tb_top;
  import lfc_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data;
  logic       hw_mode = 1'b0, term_pin = 1'b0, hiz_pin = 1'b0;
  logic       monitor_gain_pin = 1'b0, haul = 1'b0, bypass = 1'b0, tx_clock_lost = 1'b0;
  logic       rloop = 1'b0, pat_mclk = 1'b0, out_range = 1'b0;
  logic [3:0] puls = 4'h0;
  logic [1:0] patt = 2'b00, cdr = 2'b00, mark = 2'b00;
  logic [4:0] atten = 5'h00, atten_in;
  logic       range_in, slice_p, slice_n, oe_n, pwr_dn, tx_int, rx_int;
  logic       loss_ok, eq_en, long_haul, rail_p, rail_n, irq;
  logic [1:0] tx_code, rx_code;
  logic [5:0] gain_db;
  logic [8:0] window;
  logic [6:0] pct;
  logic [5:0] gains [4] = '{6'h00, 6'h16, 6'h1A, 6'h20};
  logic [3:0] pins [4] = '{4'h0, 4'h1, 4'h7, 4'h4};
  logic [1:0] codes [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  logic [7:0] ra [7] = '{ADDR_IMP, ADDR_TXPWR, ADDR_TXDRV, ADDR_EQ,
                         ADDR_EDGE, ADDR_INTA, 8'h40};
  int         n_fail = 0;
  int         n_compared = 0;

  // free-running 25 MHz master clock
  initial begin
    forever #20 clk = ~clk;
  end

  lfc_line_model line (.clk(clk), .out_of_range(out_range), .atten(atten),
    .mark(mark), .range_out(range_in), .atten_out(atten_in),
    .slice_p(slice_p), .slice_n(slice_n));

  lfc_top #(.HOLD(8'h02)) dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
    .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
    .HW_MODE(hw_mode), .TERM_PIN(term_pin), .PULSE_TEMPLATE_PINS(puls),
    .DRIVER_HIZ_PIN(hiz_pin), .PATTERN_PIN_HI(patt[1]),
    .PATTERN_PIN_LO(patt[0]), .MONITOR_GAIN_PIN(monitor_gain_pin),
    .HAUL_SELECT_PIN(haul), .EQ_RANGE_IN(range_in),
    .CABLE_ATTEN_IN(atten_in), .SLICE_P_IN(slice_p), .SLICE_N_IN(slice_n),
    .CDR_BYPASS(bypass), .CDR_P(cdr[1]), .CDR_N(cdr[0]),
    .TX_CLOCK_LOST(tx_clock_lost), .REMOTE_LOOPBACK(rloop),
    .PATTERN_BY_MCLK(pat_mclk), .TX_LINE_PAIR_OE_N(oe_n),
    .TX_POWER_DOWN(pwr_dn), .TX_TERM_INTERNAL(tx_int),
    .TX_TERM_CODE(tx_code), .RX_TERM_INTERNAL(rx_int),
    .RX_TERM_CODE(rx_code), .MONITOR_GAIN_DB(gain_db),
    .SIGNAL_LOSS_VALID(loss_ok), .EQUALIZER_ENABLE(eq_en),
    .OBSERVE_WINDOW(window), .THRESHOLD_PCT(pct), .LONG_HAUL(long_haul),
    .RX_RAIL_P(rail_p), .RX_RAIL_N(rail_n), .IRQ(irq));

  // let n edges pass, then look once the updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [8:0] exp,
                         input logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    chk_val(what, {8'h00, exp}, {8'h00, got});
  endtask

  // single-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk_val($sformatf("read %h", a), {1'b0, exp}, {1'b0, rd_data});
  endtask

  // bounded wait for the interrupt line; a hang ends the run
  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 20 && irq !== exp; i++) tick(1);
    chk_flag("irq", exp, irq);
    if (irq !== exp) give_verdict();
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    chk_flag("oe_n hold", 1'b1, oe_n);
    tick(4);
    chk_flag("oe_n run", 1'b0, oe_n);
    chk_rd(ADDR_GAIN, 8'h08);
    chk_val("window", 9'h080, window);
    foreach (ra[i]) chk_rd(ra[i], 8'h00);
    // every termination code, tx select set to 7 minus the rx select
    for (int c = 0; c < 8; c++) begin
      logic [2:0] t;
      t = 3'(7 - c);
      wr(ADDR_IMP, {2'b00, 3'(c), t});
      tick(2);
      chk_flag("tx internal", ~t[2], tx_int);
      if (!t[2]) chk_val("tx code", 9'(t[1:0]), 9'(tx_code));
      chk_flag("rx internal", ~c[2], rx_int);
      if (!c[2]) chk_val("rx code", 9'(c), 9'(rx_code));
      chk_rd(ADDR_IMP, {2'b00, 3'(c), t});
    end
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_IMP, 8'h04);
    tick(2);
    chk_flag("t1 tx internal", 1'b1, tx_int);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_TXDRV, 8'h01);
    tick(2);
    chk_flag("hiz oe_n", 1'b1, oe_n);
    chk_flag("hiz still on", 1'b0, pwr_dn);
    wr(ADDR_TXDRV, 8'h00);
    wr(ADDR_TXPWR, 8'h01);
    tick(2);
    chk_flag("pd", 1'b1, pwr_dn);
    chk_flag("pd oe_n", 1'b1, oe_n);
    wr(ADDR_TXPWR, 8'h00);
    @(posedge clk);
    tx_clock_lost <= 1'b1;
    tick(2);
    chk_flag("tx_clock lost", 1'b1, oe_n);
    @(posedge clk);
    rloop <= 1'b1;
    tick(2);
    chk_flag("loopback", 1'b0, oe_n);
    @(posedge clk);
    rloop    <= 1'b0;
    pat_mclk <= 1'b1;
    tick(2);
    chk_flag("pattern mclk", 1'b0, oe_n);
    @(posedge clk);
    tx_clock_lost <= 1'b0;
    pat_mclk  <= 1'b0;
    // each slicer, window and monitor gain code
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_GAIN, 8'(s * 8'h15));
      tick(2);
      chk_val("pct", 9'(7'h28 + 7'(s) * 7'h0A), 9'(pct));
      chk_val("window", 9'h020 << s, window);
      chk_val("gain", 9'(gains[s]), 9'(gain_db));
      chk_flag("loss valid", s == 0, loss_ok);
    end
    wr(ADDR_EQ, 8'h01);
    tick(2);
    chk_flag("equalizer_enable", 1'b1, eq_en);
    wr(ADDR_EQ, 8'h00);
    tick(2);
    chk_flag("eq off", 1'b0, eq_en);
    // equalizer status events, rise only then both edges, then masked
    wr(ADDR_MASK, 8'h01);
    out_range <= 1'b1;
    wait_irq(1'b1);
    chk_rd(ADDR_LSTAT, 8'h01);
    chk_rd(ADDR_INTA, 8'h01);
    tick(1);
    chk_flag("irq cleared", 1'b0, irq);
    chk_rd(ADDR_INTA, 8'h00);
    @(posedge clk);
    out_range <= 1'b0;
    tick(8);
    chk_flag("fall ignored", 1'b0, irq);
    chk_rd(ADDR_LSTAT, 8'h00);
    wr(ADDR_EDGE, 8'h01);
    out_range <= 1'b1;
    wait_irq(1'b1);
    chk_rd(ADDR_INTA, 8'h01);
    @(posedge clk);
    out_range <= 1'b0;
    wait_irq(1'b1);
    chk_rd(ADDR_INTA, 8'h01);
    wr(ADDR_MASK, 8'h00);
    out_range <= 1'b1;
    tick(8);
    chk_flag("masked", 1'b0, irq);
    chk_rd(ADDR_INTA, 8'h01);
    // read-only attenuation ignores writes
    @(posedge clk);
    atten <= 5'h13;
    tick(5);
    chk_rd(ADDR_CABLE, 8'h13);
    wr(ADDR_CABLE, 8'hFF);
    chk_rd(ADDR_CABLE, 8'h13);
    @(posedge clk);
    bypass <= 1'b1;
    mark   <= 2'b10;
    tick(5);
    chk_val("rails", 9'h002, {7'h00, rail_p, rail_n});
    @(posedge clk);
    mark <= 2'b01;
    tick(5);
    chk_val("rails", 9'h001, {7'h00, rail_p, rail_n});
    @(posedge clk);
    bypass <= 1'b0;
    cdr    <= 2'b10;
    tick(2);
    chk_val("cdr rails", 9'h002, {7'h00, rail_p, rail_n});
    // software long haul bit, later overridden by the haul pin
    wr(ADDR_MODE, 8'h02);
    tick(2);
    chk_flag("sw long haul", 1'b1, long_haul);
    // hardware control through the pins
    @(posedge clk);
    hw_mode  <= 1'b1;
    term_pin <= 1'b1;
    monitor_gain_pin     <= 1'b1;
    haul     <= 1'b1;
    patt     <= 2'b01;
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      puls <= pins[p];
      tick(4);
      chk_val("hw tx code", 9'(codes[p]), 9'(tx_code));
      chk_val("hw rx code", 9'(codes[p]), 9'(rx_code));
    end
    chk_val("hw gain", 9'h01A, {3'b000, gain_db});
    chk_flag("hw long haul", 1'b1, long_haul);
    chk_flag("hw one pattern pin", 1'b0, pwr_dn);
    @(posedge clk);
    patt <= 2'b11;
    tick(4);
    chk_flag("hw pd", 1'b1, pwr_dn);
    @(posedge clk);
    patt     <= 2'b10;
    hiz_pin  <= 1'b1;
    term_pin <= 1'b0;
    monitor_gain_pin     <= 1'b0;
    haul     <= 1'b0;
    tick(4);
    chk_flag("hw hiz", 1'b1, oe_n);
    chk_val("hw ext", 9'h000, {7'h00, tx_int, rx_int});
    chk_val("hw gain 0", 9'h000, {3'b000, gain_db});
    chk_flag("hw short haul", 1'b0, long_haul);
    @(posedge clk);
    hw_mode <= 1'b0;
    hiz_pin <= 1'b0;
    tick(4);
    wr(ADDR_GAIN, 8'h3F);
    wr(ADDR_MODE, 8'h80);
    tick(1);
    chk_flag("swrst oe_n", 1'b1, oe_n);
    chk_rd(ADDR_GAIN, 8'h08);
    chk_rd(ADDR_MODE, 8'h00);
    give_verdict();
  end
endmodule
